// ===== design/upsm_pkg.sv
package upsm_pkg;
  // register map, byte addresses on the 16-bit port
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_P0 = 8'h04;
  localparam logic [7:0] ADDR_P1 = 8'h06;
  // control register fields
  localparam int CB_HOST = 0;
  localparam int CB_PU = 1;
  localparam int CB_PD0 = 2;
  localparam int CB_PD1 = 3;
  localparam int CB_ACT0 = 4;
  localparam int CB_ACT1 = 5;
  localparam int CB_SPD0 = 6;
  localparam int CB_SPD1 = 8;
  localparam logic [15:0] CTRL_MASK = 16'h03FF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // status register fields
  localparam int SB_OVC_HI = 15;
  localparam int SB_OVC_LO = 14;
  localparam int SB_FRAME = 5;
  localparam int SB_ID = 2;
  // line-state codes
  localparam logic [1:0] LN_SE0 = 2'h0;
  localparam logic [1:0] LN_01 = 2'h1;
  localparam logic [1:0] LN_10 = 2'h2;
  localparam logic [1:0] LN_SE1 = 2'h3;
  // timing
  localparam int CLK_NS = 50;
  localparam int FRAME_NS = 1000000;
  localparam int UFRAME_NS = 125000;
  localparam int SOF_NS = 3000;
  localparam logic [14:0] FRAME_CYC_DEF = 15'(FRAME_NS / CLK_NS);
  localparam logic [14:0] UFRAME_CYC = 15'(UFRAME_NS / CLK_NS);
  localparam logic [14:0] SOF_CYC = 15'((SOF_NS + CLK_NS - 1) / CLK_NS);
  // signalling speed of a port
  typedef enum logic [1:0] {
    SPD_FULL = 2'h0,
    SPD_LOW = 2'h1,
    SPD_HIGH = 2'h2,
    SPD_CHIRP = 2'h3
  } upsm_speed_t;
  // frame engine states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SOF = 3'b010,
    S_GAP = 3'b100
  } upsm_sof_st_t;
  // sampled data lines of one port
  typedef struct packed {
    logic dp;
    logic dm;
    logic squelch;
  } upsm_line_t;
  // register request from the cpu
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } upsm_req_t;
endpackage

// ===== design/upsm_sof_port.sv
module upsm_sof_port
  import upsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [14:0] period,
  output logic sof_tx_q,
  output logic bus_en_q,
  output logic frame_active_q
);
  upsm_sof_st_t state_q, state_d;
  logic [14:0] frm_q, frm_d; // frame spacing timer
  logic [14:0] sof_q, sof_d; // packet length timer
  logic [14:0] len_q; // helper for checks only

  // next state; a started packet always completes
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (start) state_d = S_SOF;
      S_SOF:
      begin
        // finish the packet before idling
        if (sof_q == 15'h0000) state_d = start ? S_GAP : S_IDLE;
      end
      S_GAP:
      begin
        if (!start) state_d = S_IDLE;
        else if (frm_q == 15'h0000) state_d = S_SOF;
      end
      default: state_d = S_IDLE; // illegal one-hot code
    endcase
  end

  assign frm_d = (state_q == S_IDLE || frm_q == 15'h0000) ? period - 15'h0001
                 : frm_q - 15'h0001;
  assign sof_d = (state_q != S_SOF) ? SOF_CYC - 15'h0001 : sof_q - 15'h0001;

  // state, timers and flag outputs
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      frm_q <= 15'h0000;
      sof_q <= 15'h0000;
      sof_tx_q <= 1'b0;
      bus_en_q <= 1'b0;
      frame_active_q <= 1'b0;
      len_q <= 15'h0000;
    end
    else
    begin
      state_q <= state_d;
      frm_q <= frm_d;
      sof_q <= sof_d;
      sof_tx_q <= (state_d == S_SOF);
      bus_en_q <= (state_d != S_IDLE);
      frame_active_q <= (state_d != S_IDLE);
      len_q <= sof_tx_q ? len_q + 15'h0001 : 15'h0000;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence stop_seen;
    sof_tx_q && sof_q == 15'h0000 && !start;
  endsequence
  sequence mid_stop;
    sof_tx_q && sof_q != 15'h0000 && !start;
  endsequence

  start_flag_a: assert property (state_q == S_IDLE && start |=>
    frame_active_q && bus_en_q && sof_tx_q) else $error("start not shown");
  finish_sof_a: assert property (mid_stop |=> frame_active_q && sof_tx_q)
    else $error("packet cut short");
  flag_clear_a: assert property (stop_seen |=> !frame_active_q && !sof_tx_q)
    else $error("flag not cleared after last packet");
  sof_len_a: assert property ($fell(sof_tx_q) |-> len_q == SOF_CYC)
    else $error("packet length wrong");
  flag_cover_a: assert property (sof_tx_q |-> frame_active_q)
    else $error("packet without active flag");
endmodule

// ===== design/upsm_top.sv
// Overview of operation
// - port 0 enable in host starts frames
// - port 1 enable in host starts frames
// - disable: finish packet, then idle and clear flag on one edge
// - frame flag at bit 5, 1=running
// - id pin mirrored into port 0
// - full/low speed line-state codes
// - high speed and chirp line-state codes
// - port 1 line state host only
// - port 1 overcurrent bit 15, bit 14 zero
// - port 1 layout, unused bits zero
// - pull-downs on both lines in host
//
// Added by the designer: the address-and-strobe port and the register offsets.
module upsm_top
  import upsm_pkg::*;
#(
  parameter logic [14:0] FRAME_CYC = FRAME_CYC_DEF // full-speed frame spacing
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire upsm_pkg::upsm_req_t req,
  output logic [15:0] rdata_q,
  input wire upsm_pkg::upsm_line_t line0,
  input wire upsm_pkg::upsm_line_t line1,
  input wire logic otg_id_input,
  input wire logic ovc0_a,
  input wire logic ovc0_b,
  input wire logic overcurrent_input_second,
  output logic sof_tx0_q,
  output logic sof_tx1_q,
  output logic bus_en0_q,
  output logic bus_en1_q,
  output logic pulldown0_q,
  output logic pulldown1_q,
  output logic dplus_pullup_q
);
  import upsm_pkg::*;

  // software control state
  logic [15:0] ctrl_q; // control register
  logic [15:0] ctrl_d; // its next value

  // decoded control fields
  logic host_mode; // host function selected
  logic dplus_pullup_enable; // peripheral attach
  logic line_pulldown_enable0; // port 0 pull-downs
  logic line_pulldown_enable1; // port 1 pull-downs
  logic bus_activity_enable0; // port 0 frames
  logic bus_activity_enable1; // port 1 frames
  upsm_speed_t spd0; // port 0 signalling
  upsm_speed_t spd1; // port 1 signalling

  // frame engine hookups
  logic start0; // port 0 may run frames
  logic start1; // port 1 may run frames
  logic [14:0] period0; // port 0 spacing
  logic [14:0] period1; // port 1 spacing
  logic frame_active_flag0; // port 0 flag
  logic frame_active_flag1; // port 1 flag

  // line-state values
  logic [1:0] line_state_field0; // port 0 code
  logic [1:0] line_state_field1; // port 1 raw code
  logic [1:0] ln1_shown; // port 1 code as read
  logic ln1_valid; // port 1 code meaningful

  // status images and read path
  logic [15:0] port0_line_status; // port 0 image
  logic [15:0] port1_line_status; // port 1 image
  logic [15:0] rd_mux; // selected word
  logic [15:0] rdata_d; // next read data
  logic hit_ctrl; // control address
  logic hit_p0; // port 0 status address
  logic hit_p1; // port 1 status address

  // line-state decode shared by both ports
  function automatic logic [1:0] ln_decode(input upsm_line_t l,
                                           input upsm_speed_t s);
    logic [1:0] raw;
    raw = {l.dm, l.dp};
    ln_decode = raw;
    unique case (s)
      // full: J is d+ high so 01, K 10; low: J is d- high so 10
      SPD_FULL: ln_decode = raw;
      SPD_LOW: ln_decode = raw;
      // high speed only tells squelch from activity
      SPD_HIGH: ln_decode = l.squelch ? LN_SE0 : LN_01;
      // chirp keeps the polarity of the driven line
      SPD_CHIRP:
      begin
        if (l.squelch) ln_decode = LN_SE0;
        else ln_decode = l.dp ? LN_01 : LN_10;
      end
    endcase
  endfunction

  // field extraction
  assign host_mode = ctrl_q[CB_HOST];
  assign dplus_pullup_enable = ctrl_q[CB_PU];
  assign line_pulldown_enable0 = ctrl_q[CB_PD0];
  assign line_pulldown_enable1 = ctrl_q[CB_PD1];
  assign bus_activity_enable0 = ctrl_q[CB_ACT0];
  assign bus_activity_enable1 = ctrl_q[CB_ACT1];
  assign spd0 = upsm_speed_t'(ctrl_q[CB_SPD0 +: 2]);
  assign spd1 = upsm_speed_t'(ctrl_q[CB_SPD1 +: 2]);

  // frames only ever run in host mode
  assign start0 = bus_activity_enable0 && host_mode;
  assign start1 = bus_activity_enable1 && host_mode;

  // microframes in high speed and chirp, full frames otherwise
  assign period0 = (spd0 == SPD_HIGH || spd0 == SPD_CHIRP) ? UFRAME_CYC : FRAME_CYC;
  assign period1 = (spd1 == SPD_HIGH || spd1 == SPD_CHIRP) ? UFRAME_CYC : FRAME_CYC;

  // port 0 frame engine
  upsm_sof_port u_sof0 (
    .core_clk(core_clk),
    .rst(rst),
    .start(start0),
    .period(period0),
    .sof_tx_q(sof_tx0_q),
    .bus_en_q(bus_en0_q),
    .frame_active_q(frame_active_flag0)
  );

  // port 1 frame engine
  upsm_sof_port u_sof1 (
    .core_clk(core_clk),
    .rst(rst),
    .start(start1),
    .period(period1),
    .sof_tx_q(sof_tx1_q),
    .bus_en_q(bus_en1_q),
    .frame_active_q(frame_active_flag1)
  );

  // line decode; port 0 is shown as seen, software waits
  // for its own pull setting before trusting it
  assign line_state_field0 = ln_decode(line0, spd0);
  assign line_state_field1 = ln_decode(line1, spd1);

  // port 1 lines float in peripheral mode, so hide them
  assign ln1_valid = host_mode && line_pulldown_enable1;
  assign ln1_shown = ln1_valid ? line_state_field1 : LN_SE0;

  // port 0 image: two overcurrent pins, flag, id, line
  assign port0_line_status = {ovc0_a, ovc0_b, 8'h00,
                              frame_active_flag0,
                              2'b00,
                              otg_id_input,
                              line_state_field0};

  // port 1 image: one overcurrent pin, bit 14 held low
  assign port1_line_status = {overcurrent_input_second,
                              1'b0,
                              8'h00,
                              frame_active_flag1,
                              3'b000,
                              ln1_shown};

  // address decode
  assign hit_ctrl = (req.addr == ADDR_CTRL);
  assign hit_p0 = (req.addr == ADDR_P0);
  assign hit_p1 = (req.addr == ADDR_P1);

  // read selection; unmapped words read as zero
  assign rd_mux = hit_ctrl ? ctrl_q
                : hit_p0 ? port0_line_status
                : hit_p1 ? port1_line_status
                : 16'h0000;

  // data is only valid the cycle after the strobe
  assign rdata_d = req.rd ? rd_mux : 16'h0000;

  // only the control word takes writes; status is pure
  // wiring, so a stray write there cannot disturb it
  assign ctrl_d = (req.wr && hit_ctrl) ? (req.wdata & CTRL_MASK) : ctrl_q;

  // register and read-data flops
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // pad resistor controls, registered for glitch-free pins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pulldown0_q <= 1'b0;
      pulldown1_q <= 1'b0;
      dplus_pullup_q <= 1'b0;
    end
    else
    begin
      // both lines pulled down only as host
      pulldown0_q <= host_mode && line_pulldown_enable0;
      pulldown1_q <= host_mode && line_pulldown_enable1;
      // attach resistor belongs to peripheral mode
      dplus_pullup_q <= !host_mode && dplus_pullup_enable;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence rd_p0;
    req.rd && hit_p0;
  endsequence
  sequence rd_p1;
    req.rd && hit_p1;
  endsequence

  id_mirror_a: assert property (rd_p0 |=> rdata_q[SB_ID] == $past(otg_id_input))
    else $error("id pin not mirrored");
  flag_bit_a: assert property (rd_p0 |=> rdata_q[SB_FRAME] == $past(frame_active_flag0))
    else $error("port 0 flag bit wrong");
  ovc_mirror_a: assert property (rd_p1 |=>
    rdata_q[SB_OVC_HI] == $past(overcurrent_input_second) && !rdata_q[SB_OVC_LO])
    else $error("port 1 overcurrent bits wrong");
  p1_layout_a: assert property (rd_p1 |=>
    rdata_q[13:6] == 8'h00 && rdata_q[4:2] == 3'b000)
    else $error("port 1 unused bits set");
  p1_valid_a: assert property (rd_p1 and !host_mode |=> rdata_q[1:0] == LN_SE0)
    else $error("port 1 line shown in peripheral mode");
  hs_line_a: assert property (rd_p0 and spd0 == SPD_HIGH |=>
    rdata_q[1:0] == ($past(line0.squelch) ? LN_SE0 : LN_01))
    else $error("high speed line code wrong");
  fs_line_a: assert property (rd_p0 and spd0 == SPD_FULL |=>
    rdata_q[1:0] == {$past(line0.dm), $past(line0.dp)})
    else $error("full speed line code wrong");
  pulldown_a: assert property (##1 pulldown0_q ==
    $past(host_mode && line_pulldown_enable0))
    else $error("pull-down not following control");
  read_only_a: assert property (req.wr && !hit_ctrl |=> $stable(ctrl_q))
    else $error("write outside control changed state");
  rd_once_a: assert property (!req.rd |=> rdata_q == 16'h0000)
    else $error("read data outside its cycle");
endmodule

// ===== dv/upsm_line_model.sv
module upsm_line_model
  import upsm_pkg::*;
(
  input wire logic core_clk,
  input wire logic drive,
  input wire logic dp,
  input wire logic dm,
  input wire logic squelch,
  input wire logic pull_low,
  output upsm_pkg::upsm_line_t line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_q = 1'b0; // free toggle for released lines
  // a floating line keeps moving so no stale level can pass for a real one
  always @(posedge core_clk)
  begin
    flip_q <= ~flip_q;
  end
  // far device drives, else host pull-downs give squelched se0, else floating
  assign line = drive ? {dp, dm, squelch}
              : (pull_low ? 3'b001 : {flip_q, ~flip_q, flip_q});
endmodule

// ===== dv/usb_port_status_monitor_tb.sv
module usb_port_status_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import upsm_pkg::*;
  localparam logic [14:0] FRAME_T = 15'h00C8; // shortened frame, 200 cycles
  logic core_clk, rst;
  upsm_req_t req;
  logic [15:0] rdata_q, v;
  upsm_line_t line0, line1;
  logic otg_id_input, ovc0_a, ovc0_b, overcurrent_input_second;
  logic sof_tx0_q, sof_tx1_q, bus_en0_q, bus_en1_q, pulldown0_q, pulldown1_q, dplus_pullup_q;
  logic drv0, drv1, dp0, dm0, sq0, dp1, dm1, sq1;
  logic [31:0] lfsr;
  // periph with attach, host pd mixes; port 0 pulls always on in host so its line may be read
  logic [15:0] modes [4] = '{16'h0002, 16'h0005, 16'h000D, 16'h0007};
  int n_errors, check_count, cyc, t0;
  int ctrl, flag0, flag1; // reference model state
  upsm_top #(.FRAME_CYC(FRAME_T)) u_dut (.core_clk(core_clk), .rst(rst), .req(req),
    .rdata_q(rdata_q), .line0(line0), .line1(line1), .otg_id_input(otg_id_input),
    .ovc0_a(ovc0_a), .ovc0_b(ovc0_b), .overcurrent_input_second(overcurrent_input_second),
    .sof_tx0_q(sof_tx0_q), .sof_tx1_q(sof_tx1_q), .bus_en0_q(bus_en0_q), .bus_en1_q(bus_en1_q),
    .pulldown0_q(pulldown0_q), .pulldown1_q(pulldown1_q), .dplus_pullup_q(dplus_pullup_q));
  upsm_line_model u_far0 (.core_clk(core_clk), .drive(drv0), .dp(dp0), .dm(dm0), .squelch(sq0),
    .pull_low(pulldown0_q), .line(line0));
  upsm_line_model u_far1 (.core_clk(core_clk), .drive(drv1), .dp(dp1), .dm(dm1), .squelch(sq1),
    .pull_low(pulldown1_q), .line(line1));
  // clock, 50 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // cycle count, also the hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // line-state code the rules give for a speed and a line
  function automatic logic [1:0] ln_code(input int spd, input upsm_line_t l);
    case (spd)
      2: return l.squelch ? 2'h0 : 2'h1;
      3: return l.squelch ? 2'h0 : (l.dp ? 2'h1 : 2'h2);
      default: return {l.dm, l.dp};
    endcase
  endfunction
  // expected status word; port1 line state only valid in host with pull-downs
  function automatic logic [15:0] exp_st(input int port);
    if (port == 0)
      return {ovc0_a, ovc0_b, 8'h00, flag0[0], 2'b00, otg_id_input, ln_code((ctrl >> 6) & 3, line0)};
    return {overcurrent_input_second, 1'b0, 8'h00, flag1[0], 3'b000,
      (ctrl[0] && ctrl[3]) ? ln_code((ctrl >> 8) & 3, line1) : 2'h0};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe; model follows the control register
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
    if (a == ADDR_CTRL)
      ctrl = int'(d & CTRL_MASK);
  endtask
  // one-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  task automatic rd_chk(input int port);
    rd(port ? ADDR_P1 : ADDR_P0, v);
    check(port ? "port1 status" : "port0 status", exp_st(port), v);
  endtask
  // fresh random pins and far-side lines
  task automatic pins();
    @(posedge core_clk);
    lfsr = next_rand(lfsr);
    {otg_id_input, ovc0_a, ovc0_b, overcurrent_input_second, dp0, dm0, sq0, dp1, dm1, sq1, drv1}
      <= lfsr[10:0];
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst, drv0} = 2'b11;
    {req, otg_id_input, ovc0_a, ovc0_b, overcurrent_input_second} = '0;
    {drv1, dp0, dm0, sq0, dp1, dm1, sq1} = '0;
    {n_errors, check_count, cyc, ctrl, flag0, flag1} = '0;
    lfsr = 32'h6ab920a8;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, writes to status ignored, unmapped read is zero
    rd(ADDR_CTRL, v);
    check("ctrl reset", 16'h0000, v);
    rd(8'h0A, v);
    check("unmapped", 16'h0000, v);
    wr(ADDR_P0, 16'hFFFF);
    wr(ADDR_P1, 16'hFFFF);
    rd(ADDR_CTRL, v);
    check("ctrl after status writes", 16'h0000, v);
    rd_chk(0);
    rd_chk(1);
    $display("test reset done");
    // every speed under each mode, random lines and pins
    for (int s = 0; s < 32; s++)
    begin
      pins();
      wr(ADDR_CTRL, modes[(s >> 2) & 3] | 16'((s & 3) << 6) | 16'((s & 3) << 8));
      rd_chk(0);
      rd_chk(1);
      check("pulls", 16'({ctrl[0] & ctrl[2], ctrl[0] & ctrl[3], !ctrl[0] & ctrl[1]}),
        16'({pulldown0_q, pulldown1_q, dplus_pullup_q}));
    end
    $display("test line states done");
    // activity enable in peripheral mode starts nothing
    wr(ADDR_CTRL, 16'h0030);
    repeat (3) @(posedge core_clk);
    #1 check("periph bus", 16'h0000, 16'({bus_en1_q, bus_en0_q}));
    $display("test peripheral done");
    // host start on both ports, packet length and frame spacing
    // port 0 pull-downs on as well, so its line field stays readable
    wr(ADDR_CTRL, 16'h0035);
    @(posedge core_clk);
    @(posedge core_clk);
    #1 check("start", 16'h000F,
      16'({sof_tx1_q, sof_tx0_q, bus_en1_q, bus_en0_q}));
    // the packet rose one edge before this point, so anchor there
    t0 = cyc - 1;
    while (sof_tx0_q === 1'b1) @(posedge core_clk) #1;
    check("sof length", 16'(SOF_CYC), 16'(cyc - t0));
    while (sof_tx0_q !== 1'b1) @(posedge core_clk) #1;
    check("frame spacing", 16'(FRAME_T), 16'(cyc - t0));
    {flag0, flag1} = {32'd1, 32'd1};
    rd_chk(0);
    rd_chk(1);
    // clear mid-packet: wait for a fresh packet, so the window is known
    while (sof_tx0_q === 1'b1) @(posedge core_clk) #1;
    while (sof_tx0_q !== 1'b1) @(posedge core_clk) #1;
    t0 = cyc - 1;
    wr(ADDR_CTRL, 16'h0005);
    repeat (60)
    begin
      rd(ADDR_P0, v);
      if (v[5] !== 1'b1)
        break;
    end
    check("drop window", 16'h0001, 16'(cyc - t0 >= 60 && cyc - t0 <= 64));
    check("idle outputs", 16'h0000,
      16'({sof_tx0_q, bus_en0_q, sof_tx1_q, bus_en1_q}));
    {flag0, flag1} = '0;
    rd_chk(0);
    rd_chk(1);
    $display("test frames done");
    report_and_stop();
  end
endmodule
